// file: logic/pmc_pkg.sv
// Shared constants, command codes and carriers for the command handler
package pmc_pkg;

  // Command codes presented on the command port
  localparam logic [7:0] CMD_OPERATION   = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CFG  = 8'h02;
  localparam logic [7:0] CMD_STORE_ALL   = 8'h11;
  localparam logic [7:0] CMD_OUTPUT_EXPONENT_MODE   = 8'h20;
  localparam logic [7:0] CMD_VOUT_SET    = 8'h21;
  localparam logic [7:0] CMD_MARGIN_HI   = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO   = 8'h26;
  localparam logic [7:0] CMD_VIN_ON      = 8'h35;
  localparam logic [7:0] CMD_VIN_OFF     = 8'h36;
  localparam logic [7:0] CMD_STARTUP_DELAY_TIME   = 8'h60;
  localparam logic [7:0] CMD_STARTUP_RAMP_TIME    = 8'h61;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READBACK   = 8'h8B;
  localparam logic [7:0] CMD_VOUT_CALOFS = 8'hD0;

  // Linear formats: 5-bit exponent over 11-bit mantissa
  localparam int         EXP_MSB        = 15;
  localparam int         EXP_LSB        = 11;
  localparam int         MANT_MSB       = 10;
  localparam logic [4:0] EXP_VIN        = 5'h1D;   // -3
  localparam logic [4:0] EXP_TON        = 5'h1F;   // -1
  localparam logic [7:0] OUTPUT_EXPONENT_MODE_BYTE = 8'h14;   // linear, exponent -12

  // Mantissa limits: 32.000..46.000 V in 0.125 V, 40..500 ms in 0.5 ms
  localparam logic [10:0] VIN_MANT_MIN  = 11'h100;
  localparam logic [10:0] VIN_MANT_MAX  = 11'h170;
  localparam logic [10:0] TON_MANT_MIN  = 11'h050;
  localparam logic [10:0] TON_MANT_MAX  = 11'h3E8;
  // Setpoint limits 5.00..13.20 V in 2^-12 V
  localparam logic [15:0] VOUT_MANT_MIN = 16'h5000;
  localparam logic [15:0] VOUT_MANT_MAX = 16'hD333;

  // Bit positions in the on/off configuration byte
  localparam int CFG_ACTION  = 0;
  localparam int CFG_POL     = 1;
  localparam int CFG_PIN_REQ = 2;
  localparam int CFG_CMD     = 3;
  localparam int CFG_PU      = 4;
  localparam logic [7:0] CFG_USED_MASK = 8'h1F;

  // Bit positions in the operation byte
  localparam int OP_ON      = 7;
  localparam int OP_MRG_MSB = 5;
  localparam int OP_MRG_LSB = 2;
  localparam logic [3:0] MRG_LOW  = 4'h6;
  localparam logic [3:0] MRG_HIGH = 4'hA;

  // Reset values
  localparam logic [7:0]  RST_OPERATION = 8'h80;
  localparam logic [7:0]  RST_ON_OFF    = 8'h1F;
  localparam logic [15:0] RST_VIN_ON    = 16'hE910;
  localparam logic [15:0] RST_VIN_OFF   = 16'hE900;
  localparam logic [15:0] RST_TON       = 16'hF850;
  localparam logic [15:0] RST_VOUT      = 16'hC000;
  localparam logic [15:0] RST_MRG_HI    = 16'hC800;
  localparam logic [15:0] RST_MRG_LO    = 16'hB800;

  // Timing: one soft-start unit of 0.5 ms at a 100 ns clock
  localparam int TICK_NS       = 500000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_CYCLES_DOC = TICK_NS / CLK_PERIOD_NS;

  // Settings that go to non-volatile storage
  typedef struct packed {
    logic [15:0] vin_on;
    logic [15:0] vin_off;
    logic [15:0] startup_delay_time;
    logic [15:0] startup_ramp_time;
    logic [15:0] vout_set;
    logic [15:0] margin_hi;
    logic [15:0] margin_lo;
  } pmc_nvm_t;

  // One command presented by the bus framing logic
  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] data;
  } pmc_cmd_t;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_DELAY = 2'b01,
    ST_RISE  = 2'b10,
    ST_ON    = 2'b11
  } pmc_state_t;

endpackage

// file: logic/pmc_handler.sv
// Command handler: settings, on/off control, soft start and readback
//
// Notes on behaviour
// (RULE1) Works with bus clocks 100 kHz or 400 kHz
// (RULE2) Output voltage words: unsigned mantissa, 2^-12
// (RULE3) Other words: 11-bit mantissa, 5-bit exponent
// (RULE4) Operation bit 7 requests output on
// (RULE5) Only five low config bits used, default ones
// (RULE6) Command bit clear ignores operation on bit
// (RULE7) Gating bit waits for pin and command
// (RULE8) Pin-required bit needs asserted on/off pin
// (RULE9) Input thresholds 32 to 46 V, 0.125 V
// (RULE10) Host keeps turn-on 2 V above turn-off
// (RULE11) Input thresholds: exponent -3, mantissa top zero
// (RULE12) Start delay 40 to 500 ms, 0.5 ms
// (RULE13) Ramp time 40 to 500 ms, 0.5 ms
// (RULE14) Timing words: exponent -1, mantissa top zero
// (RULE15) Setpoint clamped 5.00 to 13.20 V
// (RULE16) Mode read returns exponent minus twelve
// (RULE17) Operation bits 5:2 select margin low/high
// (RULE18) Store command saves thresholds, timings, setpoints
// (RULE19) Output read returns 16-bit unsigned mantissa
// (RULE20) Offset correction read returns signed 16-bit value
// (RULE21) Settings act at once, saved only on store
// (RULE22) Exponents fixed per command, host cannot change
// (RULE23) Enable request combines on bit and pin
module pmc_handler
  import pmc_pkg::*;
#(
  parameter int          TICK_CYCLES  = TICK_CYCLES_DOC,
  parameter logic [15:0] VOUT_CAL_OFS = 16'h0000
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire pmc_cmd_t    cmd,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  output logic             cmd_err,
  input  wire logic        onoff_pin,
  input  wire logic [15:0] vout_adc,
  input  wire logic        nvm_load,
  input  wire pmc_nvm_t    nvm_image_in,
  output logic             nvm_store,
  output pmc_nvm_t         nvm_image_out,
  output logic             out_enable,
  output logic             ramp_active,
  output logic [15:0]      vout_target,
  output logic [10:0]      vin_on_mant,
  output logic [10:0]      vin_off_mant
);

  logic        rst_meta_r;
  logic        rst_sync_r;
  logic [7:0]  operation_r;
  logic [7:0]  on_off_cfg_r;
  pmc_nvm_t    set_r;
  pmc_state_t  state_r;
  pmc_state_t  state_nxt;
  logic [12:0] tick_cnt_r;
  logic        tick;
  logic [10:0] time_cnt_r;
  logic [15:0] rd_data_nxt;
  logic        rd_ok;
  logic        wr_ok;
  logic        pin_active;
  logic        en_req;
  logic [3:0]  margin_sel;
  logic [16:0] vout_sum;

  // Clamp an 11-bit mantissa and force the command's own exponent
  function automatic logic [15:0] lin11_fix(input logic [15:0] w,
                                            input logic [4:0]  e,
                                            input logic [10:0] lo,
                                            input logic [10:0] hi);
    logic [10:0] m;
    m = w[MANT_MSB:0];
    if (m < lo) begin
      m = lo;
    end else if (m > hi) begin
      m = hi;
    end
    return {e, m};
  endfunction

  // Clamp an unsigned 16-bit output voltage mantissa
  function automatic logic [15:0] vout_fix(input logic [15:0] w);
    logic [15:0] m;
    m = w;
    if (m < VOUT_MANT_MIN) begin
      m = VOUT_MANT_MIN;
    end else if (m > VOUT_MANT_MAX) begin
      m = VOUT_MANT_MAX;
    end
    return m;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Command decode; one command per clock, any bus rate
  always_comb begin
    wr_ok = 1'b1;
    if (cmd.code == CMD_OPERATION) begin
      wr_ok = 1'b1;
    end else if (cmd.code == CMD_ON_OFF_CFG) begin
      wr_ok = 1'b1;
    end else if (cmd.code == CMD_STORE_ALL) begin
      wr_ok = 1'b1;
    end else if (cmd.code == CMD_VOUT_SET) begin
      wr_ok = 1'b1;
    end else if (cmd.code == CMD_MARGIN_HI) begin
      wr_ok = 1'b1;
    end else if (cmd.code == CMD_MARGIN_LO) begin
      wr_ok = 1'b1;
    end else if (cmd.code == CMD_VIN_ON) begin
      wr_ok = 1'b1;
    end else if (cmd.code == CMD_VIN_OFF) begin
      wr_ok = 1'b1;
    end else if (cmd.code == CMD_STARTUP_DELAY_TIME) begin
      wr_ok = 1'b1;
    end else if (cmd.code == CMD_STARTUP_RAMP_TIME) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;  // Read-only or unknown code
    end
  end  // [RULE1]

  // Operation and on/off configuration bytes
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      operation_r  <= RST_OPERATION;
      on_off_cfg_r <= RST_ON_OFF;  // [RULE5]
    end else if (cmd_wr && cmd.code == CMD_OPERATION) begin
      operation_r <= cmd.data[7:0];  // [RULE4] [RULE17]
    end else if (cmd_wr && cmd.code == CMD_ON_OFF_CFG) begin
      on_off_cfg_r <= cmd.data[7:0] & CFG_USED_MASK;  // [RULE5]
    end
  end

  // Storable settings; writes act at once, exponents forced
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      set_r.vin_on    <= RST_VIN_ON;
      set_r.vin_off   <= RST_VIN_OFF;
      set_r.startup_delay_time <= RST_TON;
      set_r.startup_ramp_time  <= RST_TON;
      set_r.vout_set  <= RST_VOUT;
      set_r.margin_hi <= RST_MRG_HI;
      set_r.margin_lo <= RST_MRG_LO;
    end else if (nvm_load) begin
      set_r <= nvm_image_in;
    end else if (cmd_wr) begin
      if (cmd.code == CMD_VIN_ON) begin
        set_r.vin_on <= lin11_fix(cmd.data, EXP_VIN, VIN_MANT_MIN,
                                  VIN_MANT_MAX);  // [RULE9] [RULE11]
      end else if (cmd.code == CMD_VIN_OFF) begin
        set_r.vin_off <= lin11_fix(cmd.data, EXP_VIN, VIN_MANT_MIN,
                                   VIN_MANT_MAX);  // [RULE9] [RULE22]
      end else if (cmd.code == CMD_STARTUP_DELAY_TIME) begin
        set_r.startup_delay_time <= lin11_fix(cmd.data, EXP_TON, TON_MANT_MIN,
                                     TON_MANT_MAX);  // [RULE12] [RULE14]
      end else if (cmd.code == CMD_STARTUP_RAMP_TIME) begin
        set_r.startup_ramp_time <= lin11_fix(cmd.data, EXP_TON, TON_MANT_MIN,
                                    TON_MANT_MAX);  // [RULE13] [RULE3]
      end else if (cmd.code == CMD_VOUT_SET) begin
        set_r.vout_set <= vout_fix(cmd.data);  // [RULE15] [RULE2]
      end else if (cmd.code == CMD_MARGIN_HI) begin
        set_r.margin_hi <= vout_fix(cmd.data);  // [RULE2]
      end else if (cmd.code == CMD_MARGIN_LO) begin
        set_r.margin_lo <= vout_fix(cmd.data);  // [RULE2]
      end
    end
  end

  // Commit to non-volatile storage only on the store command
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      nvm_store     <= 1'b0;
      nvm_image_out <= '0;
    end else begin
      nvm_store <= cmd_wr && cmd.code == CMD_STORE_ALL;  // [RULE21]
      if (cmd_wr && cmd.code == CMD_STORE_ALL) begin
        nvm_image_out <= set_r;  // [RULE18]
      end
    end
  end

  // Corrected output reading, saturated to the unsigned range
  assign vout_sum = {1'b0, vout_adc} +
                    {VOUT_CAL_OFS[15], VOUT_CAL_OFS};  // [RULE20]

  // Read data selection
  always_comb begin
    rd_data_nxt = 16'h0000;
    rd_ok       = 1'b1;
    if (cmd.code == CMD_OPERATION) begin
      rd_data_nxt = {8'h00, operation_r};
    end else if (cmd.code == CMD_ON_OFF_CFG) begin
      rd_data_nxt = {8'h00, on_off_cfg_r};
    end else if (cmd.code == CMD_OUTPUT_EXPONENT_MODE) begin
      rd_data_nxt = {8'h00, OUTPUT_EXPONENT_MODE_BYTE};  // [RULE16]
    end else if (cmd.code == CMD_VOUT_SET) begin
      rd_data_nxt = set_r.vout_set;
    end else if (cmd.code == CMD_MARGIN_HI) begin
      rd_data_nxt = set_r.margin_hi;
    end else if (cmd.code == CMD_MARGIN_LO) begin
      rd_data_nxt = set_r.margin_lo;
    end else if (cmd.code == CMD_VIN_ON) begin
      rd_data_nxt = set_r.vin_on;
    end else if (cmd.code == CMD_VIN_OFF) begin
      rd_data_nxt = set_r.vin_off;
    end else if (cmd.code == CMD_STARTUP_DELAY_TIME) begin
      rd_data_nxt = set_r.startup_delay_time;
    end else if (cmd.code == CMD_STARTUP_RAMP_TIME) begin
      rd_data_nxt = set_r.startup_ramp_time;
    end else if (cmd.code == CMD_OUTPUT_VOLTAGE_READBACK) begin
      if (VOUT_CAL_OFS[15] && vout_sum[16]) begin
        rd_data_nxt = 16'h0000;  // Underflow clamps to zero
      end else if (!VOUT_CAL_OFS[15] && vout_sum[16]) begin
        rd_data_nxt = 16'hFFFF;  // Overflow clamps to full scale
      end else begin
        rd_data_nxt = vout_sum[15:0];  // [RULE19]
      end
    end else if (cmd.code == CMD_VOUT_CALOFS) begin
      rd_data_nxt = VOUT_CAL_OFS;  // [RULE20]
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read answer one clock after the request; errors pulse
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
      cmd_err  <= 1'b0;
    end else begin
      rd_valid <= cmd_rd;
      if (cmd_rd) begin
        rd_data <= rd_data_nxt;
      end
      cmd_err <= (cmd_rd && !rd_ok) || (cmd_wr && !wr_ok);
    end
  end

  // Enable request from pin and operation command
  assign pin_active = on_off_cfg_r[CFG_POL] ? onoff_pin : !onoff_pin;
  assign en_req = !on_off_cfg_r[CFG_PU] ||                     // [RULE7]
                  ((!on_off_cfg_r[CFG_CMD] ||                   // [RULE6]
                    operation_r[OP_ON]) &&                      // [RULE4]
                   (!on_off_cfg_r[CFG_PIN_REQ] || pin_active)); // [RULE8]
  // [RULE23]

  // Half-millisecond tick for delay and ramp timing
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      tick_cnt_r <= '0;
    end else if (state_r == ST_OFF || state_r == ST_ON ||
                 tick_cnt_r == 13'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 13'd1;
    end
  end
  assign tick = tick_cnt_r == 13'(TICK_CYCLES - 1);

  // Start-up sequence: delay, then soft-start ramp, then on
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (en_req) begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!en_req) begin
          state_nxt = ST_OFF;
        end else if (tick && time_cnt_r ==
                     set_r.startup_delay_time[MANT_MSB:0] - 11'd1) begin
          state_nxt = ST_RISE;  // [RULE12]
        end
      end
      ST_RISE: begin
        if (!en_req) begin
          state_nxt = ST_OFF;
        end else if (tick && time_cnt_r ==
                     set_r.startup_ramp_time[MANT_MSB:0] - 11'd1) begin
          state_nxt = ST_ON;  // [RULE13]
        end
      end
      ST_ON: begin
        if (!en_req) begin
          state_nxt = ST_OFF;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  // State and unit counter
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r    <= ST_OFF;
      time_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        time_cnt_r <= '0;
      end else if (tick) begin
        time_cnt_r <= time_cnt_r + 11'd1;
      end
    end
  end

  assign margin_sel = operation_r[OP_MRG_MSB:OP_MRG_LSB];

  // Registered converter controls and target voltage
  always_ff @(posedge clk_sys or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      out_enable   <= 1'b0;
      ramp_active  <= 1'b0;
      vout_target  <= RST_VOUT;
      vin_on_mant  <= RST_VIN_ON[MANT_MSB:0];
      vin_off_mant <= RST_VIN_OFF[MANT_MSB:0];
    end else begin
      out_enable  <= state_nxt == ST_RISE || state_nxt == ST_ON;
      ramp_active <= state_nxt == ST_RISE;
      if (margin_sel == MRG_LOW) begin
        vout_target <= set_r.margin_lo;  // [RULE17]
      end else if (margin_sel == MRG_HIGH) begin
        vout_target <= set_r.margin_hi;  // [RULE17]
      end else begin
        vout_target <= set_r.vout_set;
      end
      vin_on_mant  <= set_r.vin_on[MANT_MSB:0];  // [RULE10]
      vin_off_mant <= set_r.vin_off[MANT_MSB:0];
    end
  end

endmodule

// file: bench/pmc_handler_asserts.sv
// Port-level checker for the power command handler
module pmc_handler_asserts
  import pmc_pkg::*;
#(
  parameter logic [15:0] VOUT_CAL_OFS = 16'h0000
) (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        cmd_wr,
  input wire logic        cmd_rd,
  input wire pmc_cmd_t    cmd,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        cmd_err,
  input wire logic        nvm_store,
  input wire logic        out_enable,
  input wire logic        ramp_active,
  input wire logic [10:0] vin_on_mant,
  input wire logic [10:0] vin_off_mant
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Read answers carry the fixed formats
  property p_mode;
    cmd_rd && cmd.code == CMD_OUTPUT_EXPONENT_MODE |=> rd_valid && rd_data == 16'h0014;
  endproperty
  a_mode: assert property (p_mode) else $error("mode byte wrong");
  property p_cal;
    cmd_rd && cmd.code == CMD_VOUT_CALOFS |=> rd_valid
      && rd_data == VOUT_CAL_OFS;
  endproperty
  a_cal: assert property (p_cal) else $error("offset read wrong");
  property p_set;
    cmd_rd && cmd.code == CMD_VOUT_SET |=> rd_valid
      && rd_data >= VOUT_MANT_MIN && rd_data <= VOUT_MANT_MAX;
  endproperty
  a_set: assert property (p_set) else $error("setpoint range");
  property p_vin_fmt;
    cmd_rd && cmd.code == CMD_VIN_ON |=> rd_data[15:11] == EXP_VIN
      && !rd_data[10];
  endproperty
  a_vin_fmt: assert property (p_vin_fmt) else $error("vin format");
  property p_cfg;
    cmd_rd && cmd.code == CMD_ON_OFF_CFG |=> rd_data[15:5] == 11'h000;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config upper bits");
  // Store pulse follows the store command only
  property p_store;
    cmd_wr && cmd.code == CMD_STORE_ALL |=> nvm_store;
  endproperty
  a_store: assert property (p_store) else $error("no store");
  property p_no_store;
    !(cmd_wr && cmd.code == CMD_STORE_ALL) |=> !nvm_store;
  endproperty
  a_no_store: assert property (p_no_store)
    else $error("stray store");
  property p_ro;
    cmd_wr && (cmd.code == CMD_OUTPUT_EXPONENT_MODE || cmd.code == CMD_OUTPUT_VOLTAGE_READBACK)
      |=> cmd_err;
  endproperty
  a_ro: assert property (p_ro)
    else $error("read-only write taken");
  property p_vin;
    vin_on_mant >= VIN_MANT_MIN && vin_on_mant <= VIN_MANT_MAX
      && vin_off_mant >= VIN_MANT_MIN && vin_off_mant <= VIN_MANT_MAX;
  endproperty
  a_vin: assert property (p_vin) else $error("threshold range");
  // Soft start ramp stays active for at least 8 clocks after enable rises
  property p_rise;
    $rose(out_enable) |-> ramp_active [*8];
  endproperty
  a_rise: assert property (p_rise) else $error("ramp missing");
  property p_ramp_en;
    ramp_active |-> out_enable;
  endproperty
  a_ramp_en: assert property (p_ramp_en)
    else $error("ramp while off");
endmodule

bind pmc_handler pmc_handler_asserts #(.VOUT_CAL_OFS(VOUT_CAL_OFS)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_err(cmd_err),
  .nvm_store(nvm_store), .out_enable(out_enable),
  .ramp_active(ramp_active), .vin_on_mant(vin_on_mant),
  .vin_off_mant(vin_off_mant)
);

// file: bench/pmc_host_model.sv
// Host-side model issuing commands on the command port
module pmc_host_model
  import pmc_pkg::*;
(
  input wire logic clk_sys,
  output logic     cmd_wr,
  output logic     cmd_rd,
  output pmc_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd = '0;
  end

  // One strobe cycle; idle bus shows no stale command
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d);
    @(negedge clk_sys);
    cmd = {c, d};
    cmd_wr = w;
    cmd_rd = !w;
    @(negedge clk_sys);
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd = ~cmd;
  endtask

  // Thresholds sent with turn-on kept 2 V above turn-off
  task automatic set_vin(input logic [10:0] on_m, input logic [10:0] off_m);
    if (on_m < off_m + 11'd16) on_m = off_m + 11'd16;
    xfer(1'b1, CMD_VIN_ON, {EXP_VIN, on_m});
    xfer(1'b1, CMD_VIN_OFF, {EXP_VIN, off_m});
  endtask
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the power command handler
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  err_total++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module tb_top
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] CAL = 16'hfff0;
  localparam logic [7:0]  RC [10] = '{CMD_OPERATION, CMD_ON_OFF_CFG,
    CMD_VIN_ON, CMD_VIN_OFF, CMD_STARTUP_DELAY_TIME, CMD_STARTUP_RAMP_TIME, CMD_VOUT_SET,
    CMD_MARGIN_HI, CMD_MARGIN_LO, CMD_OUTPUT_EXPONENT_MODE};
  localparam logic [15:0] RV [10] = '{16'h0080, 16'h001f, RST_VIN_ON,
    RST_VIN_OFF, RST_TON, RST_TON, RST_VOUT, RST_MRG_HI, RST_MRG_LO,
    16'h0014};
  localparam logic [7:0]  OPS [3] = '{8'h98, 8'ha8, 8'h84};
  localparam logic [15:0] TGT [3] = '{16'h6000, 16'hd000, 16'h7000};
  logic        clk_sys = 1'b0;
  logic        nrst, cmd_wr, cmd_rd, rd_valid, cmd_err, onoff_pin;
  logic        nvm_load, nvm_store, out_enable, ramp_active;
  pmc_cmd_t    cmd;
  pmc_nvm_t    nvm_image_in, nvm_image_out, sh;
  logic [15:0] rd_data, vout_adc, vout_target, e_v, v, adc;
  logic [10:0] vin_on_mant, vin_off_mant, m;
  logic [15:0] exp_q[$];
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          i;
  int          seed = 32'haeb7_d81b;

  pmc_host_model u_host (.clk_sys(clk_sys), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd(cmd));
  pmc_handler #(.TICK_CYCLES(4), .VOUT_CAL_OFS(CAL)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_err(cmd_err),
    .onoff_pin(onoff_pin), .vout_adc(vout_adc), .nvm_load(nvm_load),
    .nvm_image_in(nvm_image_in), .nvm_store(nvm_store),
    .nvm_image_out(nvm_image_out), .out_enable(out_enable),
    .ramp_active(ramp_active), .vout_target(vout_target),
    .vin_on_mant(vin_on_mant), .vin_off_mant(vin_off_mant));

  always #50 clk_sys = ~clk_sys;

  task end_sim;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  // Each read answer is matched with the oldest note
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      e_v = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
      `CHK(rd_data, e_v)
    end
  end

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, c, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b1, c, d);
  endtask
  task automatic wait_lvl(input logic sel, input logic lvl, input int n);
    for (int k = 0; k < n; k++) begin
      if ((sel ? ramp_active : out_enable) === lvl) break;
      @(negedge clk_sys);
    end
  endtask

  initial begin
    nrst = 1'b0;
    onoff_pin = 1'b0;
    vout_adc = 16'h0000;
    nvm_load = 1'b0;
    nvm_image_in = '0;
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (i = 0; i < 10; i++) rd(RC[i], RV[i]);
    // Out-of-range words clamp, host exponent ignored
    wr(CMD_VIN_ON, 16'h07ff);
    rd(CMD_VIN_ON, 16'he970);
    wr(CMD_VIN_OFF, 16'h0000);
    rd(CMD_VIN_OFF, 16'he900);
    wr(CMD_STARTUP_DELAY_TIME, 16'h0001);
    rd(CMD_STARTUP_DELAY_TIME, 16'hf850);
    wr(CMD_STARTUP_RAMP_TIME, 16'h07ff);
    rd(CMD_STARTUP_RAMP_TIME, 16'hfbe8);
    wr(CMD_VOUT_SET, 16'h1000);
    rd(CMD_VOUT_SET, 16'h5000);
    wr(CMD_VOUT_SET, 16'hffff);
    rd(CMD_VOUT_SET, 16'hd333);
    wr(CMD_ON_OFF_CFG, 16'h00ff);
    rd(CMD_ON_OFF_CFG, 16'h001f);
    // Random legal thresholds and setpoints
    for (i = 0; i < 4; i++) begin
      m = VIN_MANT_MIN + 11'(($random(seed) & 32'h3f) + 16);
      u_host.set_vin(m, m - 11'd16);
      rd(CMD_VIN_ON, {EXP_VIN, m});
      `CHK(vin_off_mant, m - 11'd16)
      v = VOUT_MANT_MIN + 16'($random(seed) & 32'h7fff);
      wr(CMD_VOUT_SET, v);
      rd(CMD_VOUT_SET, v);
    end
    wr(CMD_MARGIN_HI, 16'hd000);
    wr(CMD_MARGIN_LO, 16'h6000);
    sh = {EXP_VIN, m, EXP_VIN, m - 11'd16, 16'hf850, 16'hfbe8, v,
          16'hd000, 16'h6000};
    // Store commits live settings, later writes stay volatile
    wr(CMD_STORE_ALL, 16'h0000);
    `CHK(nvm_store, 1'b1)
    @(negedge clk_sys);
    `CHK(nvm_image_out, sh)
    wr(CMD_VOUT_SET, 16'h7000);
    rd(CMD_VOUT_SET, 16'h7000);
    `CHK(nvm_image_out, sh)
    // Read-only places refuse writes; readback with offset
    wr(CMD_OUTPUT_VOLTAGE_READBACK, 16'h1234);
    `CHK(cmd_err, 1'b1)
    wr(CMD_OUTPUT_EXPONENT_MODE, 16'h0000);
    rd(CMD_OUTPUT_EXPONENT_MODE, 16'h0014);
    for (i = 0; i < 3; i++) begin
      adc = (i == 0) ? 16'h0008 : 16'($random(seed));
      vout_adc = adc;
      rd(CMD_OUTPUT_VOLTAGE_READBACK, adc < 16'h0010 ? 16'h0000 : adc + CAL);
    end
    rd(CMD_VOUT_CALOFS, CAL);
    // Margin selection
    for (i = 0; i < 3; i++) begin
      wr(CMD_OPERATION, {8'h00, OPS[i]});
      @(negedge clk_sys);
      `CHK(vout_target, TGT[i])
    end
    // Start-up needs pin, then delay, then ramp
    repeat (400) @(negedge clk_sys);
    `CHK(out_enable, 1'b0)
    onoff_pin = 1'b1;
    repeat (300) @(negedge clk_sys);
    `CHK(out_enable, 1'b0)
    wait_lvl(1'b0, 1'b1, 60);
    `CHK({out_enable, ramp_active}, 2'b11)
    repeat (3900) @(negedge clk_sys);
    `CHK(ramp_active, 1'b1)
    wait_lvl(1'b1, 1'b0, 300);
    `CHK({out_enable, ramp_active}, 2'b10)
    // On bit, ignored on bit, pin loss, pin not required
    wr(CMD_OPERATION, 16'h0004);
    wait_lvl(1'b0, 1'b0, 4);
    `CHK(out_enable, 1'b0)
    wr(CMD_ON_OFF_CFG, 16'h0017);
    wait_lvl(1'b0, 1'b1, 400);
    `CHK(out_enable, 1'b1)
    repeat (8) @(negedge clk_sys);
    onoff_pin = 1'b0;
    wait_lvl(1'b0, 1'b0, 4);
    `CHK(out_enable, 1'b0)
    wr(CMD_ON_OFF_CFG, 16'h001b);
    wr(CMD_OPERATION, 16'h0080);
    wait_lvl(1'b0, 1'b1, 400);
    `CHK(out_enable, 1'b1)
    // Stored image reloads as the live settings
    nvm_image_in = sh;
    nvm_load = 1'b1;
    @(negedge clk_sys);
    nvm_load = 1'b0;
    rd(CMD_VOUT_SET, sh.vout_set);
    @(negedge clk_sys);
    end_sim();
  end
endmodule
